// *** rtl/acl_match_pkg.sv ***
// constants, field layouts and carrier types of the acl match engine
// assumes a word-addressed register port and a parsed-header strobe per frame
// Function
// RULE1: processing entry points to one action entry
// RULE2: selection mask bits AND the chosen results
// RULE3: lowest action pointer wins, one action
// RULE4: shared action pointer ORs the selection sets
// RULE5: layer select disables or picks rule format
// RULE6: layer 2 option picks count, mac, type
// RULE7: compare stored mac address and ethertype
// RULE8: polarity bit picks equal or unequal true
// RULE9: count value from same-index action low bits
// RULE10: counting entry's action does no forwarding
// RULE11: time unit bit picks microsecond or millisecond
// RULE12: watchdog counts down, event on expiry
// RULE13: event counter counts frames, event at terminal
// RULE14: layer 3 masked single or unmasked both
// RULE15: select bit picks destination or source address
// RULE16: mask bit set excludes that address bit
// RULE17: unmasked mode compares source and destination
// RULE18: layer 4 option picks protocol, ports, sequence
// RULE19: all sixteen rules evaluated every frame
// RULE20: counting rules raise events, not actions
// RULE21: no hit leaves forwarding and priority unchanged
package acl_match_pkg;
    // ----------------------------------------------------------------
    // table geometry
    // ----------------------------------------------------------------
    localparam int ENTRIES = 16;
    localparam int IDX_W = 4;
    localparam int SEL_W = 3;
    localparam int ADDR_W = IDX_W + SEL_W;
    localparam int CNT_W = 11;
    localparam int FWD_W = 7;
    // ----------------------------------------------------------------
    // register word selects inside one entry (address = {entry, sel})
    // ----------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_MATCH_CTRL = 3'h0;
    localparam logic [SEL_W-1:0] SEL_MATCH_D0 = 3'h1;
    localparam logic [SEL_W-1:0] SEL_MATCH_D1 = 3'h2;
    localparam logic [SEL_W-1:0] SEL_MATCH_D2 = 3'h3;
    localparam logic [SEL_W-1:0] SEL_ACTION = 3'h4;
    localparam logic [SEL_W-1:0] SEL_PROC = 3'h5;
    localparam logic [SEL_W-1:0] SEL_COUNT = 3'h6;
    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] LAYER_OFF = 2'h0;
    localparam logic [1:0] LAYER_L2 = 2'h1;
    localparam logic [1:0] LAYER_L3 = 2'h2;
    localparam logic [1:0] LAYER_L4 = 2'h3;
    localparam logic [1:0] L2_COUNT = 2'h0;
    localparam logic [1:0] L2_MAC = 2'h1;
    localparam logic [1:0] L2_TYPE = 2'h2;
    localparam logic [1:0] L3_MASKED = 2'h1;
    localparam logic [1:0] L3_BOTH = 2'h2;
    localparam logic [1:0] L4_PROTO = 2'h0;
    localparam logic [1:0] L4_TCP_PORT = 2'h1;
    localparam logic [1:0] L4_UDP_PORT = 2'h2;
    localparam logic [1:0] PORT_NONE = 2'h0;
    localparam logic [1:0] PORT_EITHER = 2'h1;
    localparam logic [1:0] PORT_IN_RANGE = 2'h2;
    // ----------------------------------------------------------------
    // layer 4 parameter word (d2) field positions
    // ----------------------------------------------------------------
    localparam int D2_PC_LO = 0;
    localparam int D2_PRO_LO = 2;
    localparam int D2_FME = 10;
    localparam int D2_FMASK_LO = 11;
    localparam int D2_FLAG_LO = 19;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int US_NS = 1000;
    localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;
    localparam int US_PER_MS = 1000;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] match_layer_select;
        logic [1:0] match_option_select;
        logic src_dst;
        logic equal_polarity;
    } match_ctrl_s;
    typedef struct packed {
        logic [FWD_W-1:0] forward;
        logic count_algorithm;
        logic count_time_unit;
        logic [1:0] map_mode_field;
        logic [2:0] remark_value_field;
        logic remark_enable_field;
        logic [2:0] priority_value;
        logic [1:0] priority_mode_field;
    } action_rule_s;
    typedef struct packed {
        logic [ENTRIES-1:0] match_select_mask;
        logic [IDX_W-1:0] action_pointer;
    } proc_entry_s;
    typedef struct packed {
        logic [47:0] dst_mac;
        logic [47:0] src_mac;
        logic [15:0] ethertype;
        logic ip_valid;
        logic [31:0] dst_ip;
        logic [31:0] src_ip;
        logic [7:0] protocol;
        logic is_tcp;
        logic is_udp;
        logic [15:0] src_port;
        logic [15:0] dst_port;
        logic [31:0] tcp_seq;
        logic [7:0] tcp_flags;
    } frame_hdr_s;
    typedef struct packed {
        logic hit;
        logic [IDX_W-1:0] index;
        logic [1:0] priority_mode_field;
        logic [2:0] priority_value;
        logic remark_enable_field;
        logic [2:0] remark_value_field;
        logic [1:0] map_mode_field;
        logic [FWD_W-1:0] forward;
    } decision_s;
    localparam int ACTION_W = $bits(action_rule_s);
    localparam int PROC_W = $bits(proc_entry_s);
    localparam int CTRL_W = $bits(match_ctrl_s);
endpackage

// *** rtl/acl_match_engine.sv ***
// ingress access control list evaluator: tables, compare, select, counters
// assumes one parsed header per FRAME_VALID pulse and a one-cycle register port
`timescale 1ns/1ps
module acl_match_engine
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [acl_match_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    output logic [31:0] REG_RDATA,
    input wire logic FRAME_VALID,
    input wire acl_match_pkg::frame_hdr_s FRAME_HDR,
    output logic DECISION_VALID,
    output acl_match_pkg::decision_s DECISION,
    output logic [acl_match_pkg::ENTRIES-1:0] COUNT_EVENT
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        acl_match_pkg::match_ctrl_s [acl_match_pkg::ENTRIES-1:0] mctrl;
        logic [acl_match_pkg::ENTRIES-1:0][31:0] d0;
        logic [acl_match_pkg::ENTRIES-1:0][31:0] d1;
        logic [acl_match_pkg::ENTRIES-1:0][31:0] d2;
        acl_match_pkg::action_rule_s [acl_match_pkg::ENTRIES-1:0] act;
        acl_match_pkg::proc_entry_s [acl_match_pkg::ENTRIES-1:0] proc;
        logic [acl_match_pkg::ENTRIES-1:0][acl_match_pkg::CNT_W-1:0] cnt;
        logic [4:0] us_div;
        logic [9:0] ms_div;
        logic us_tick;
        logic ms_tick;
        logic [31:0] rdata;
        logic dec_valid;
        acl_match_pkg::decision_s dec;
        logic [acl_match_pkg::ENTRIES-1:0] event_out;
    } state_s;

    state_s st;
    state_s next_st;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_count_mode(input acl_match_pkg::match_ctrl_s c);
        is_count_mode = (c.match_layer_select == acl_match_pkg::LAYER_L2) &&
            (c.match_option_select == acl_match_pkg::L2_COUNT);
    endfunction

    function automatic logic port_test(input logic [1:0] pc, input logic [15:0] port,
                                       input logic [31:0] d0);
        logic [15:0] max_port;
        logic [15:0] min_port;
        logic in_range;
        max_port = d0[31:16];
        min_port = d0[15:0];
        in_range = (port >= min_port) && (port <= max_port);
        case (pc)
            acl_match_pkg::PORT_NONE: port_test = 1'b1;
            acl_match_pkg::PORT_EITHER: port_test = (port == max_port) || (port == min_port);
            acl_match_pkg::PORT_IN_RANGE: port_test = in_range;
            default: port_test = !in_range;
        endcase
    endfunction

    // result of one matching rule against one header, polarity applied
    function automatic logic rule_result(input acl_match_pkg::match_ctrl_s c,
                                         input logic [31:0] d0, input logic [31:0] d1,
                                         input logic [31:0] d2,
                                         input acl_match_pkg::frame_hdr_s h);
        logic applies;
        logic raw;
        logic mac_eq;
        logic type_eq;
        logic [47:0] mac;
        logic [31:0] addr;
        logic [15:0] port;
        logic [7:0] fmask;
        logic flag_ok;
        applies = 1'b0;
        raw = 1'b0;
        mac = c.src_dst ? h.src_mac : h.dst_mac;
        mac_eq = (mac == {d1[15:0], d0}); // [RULE7]
        type_eq = (h.ethertype == d1[31:16]); // [RULE7]
        addr = c.src_dst ? h.src_ip : h.dst_ip; // [RULE15]
        port = c.src_dst ? h.src_port : h.dst_port;
        fmask = d2[acl_match_pkg::D2_FMASK_LO +: 8];
        flag_ok = !d2[acl_match_pkg::D2_FME] ||
            (((h.tcp_flags ^ d2[acl_match_pkg::D2_FLAG_LO +: 8]) & ~fmask) == 8'h00);
        case (c.match_layer_select) // [RULE5]
            acl_match_pkg::LAYER_L2:
            begin
                applies = 1'b1;
                case (c.match_option_select) // [RULE6]
                    acl_match_pkg::L2_MAC: raw = mac_eq;
                    acl_match_pkg::L2_TYPE: raw = type_eq;
                    default: raw = mac_eq && type_eq;
                endcase
            end
            acl_match_pkg::LAYER_L3:
            begin
                applies = h.ip_valid;
                case (c.match_option_select) // [RULE14]
                    acl_match_pkg::L3_MASKED: raw = ((addr ^ d0) & ~d1) == 32'h0; // [RULE16]
                    acl_match_pkg::L3_BOTH: raw = (h.src_ip == d0) && (h.dst_ip == d1); // [RULE17]
                    default: applies = 1'b0;
                endcase
            end
            acl_match_pkg::LAYER_L4:
            begin
                case (c.match_option_select) // [RULE18]
                    acl_match_pkg::L4_PROTO:
                    begin
                        applies = h.ip_valid;
                        raw = (h.protocol == d2[acl_match_pkg::D2_PRO_LO +: 8]);
                    end
                    acl_match_pkg::L4_TCP_PORT:
                    begin
                        applies = h.is_tcp;
                        raw = port_test(d2[acl_match_pkg::D2_PC_LO +: 2], port, d0) && flag_ok;
                    end
                    acl_match_pkg::L4_UDP_PORT:
                    begin
                        applies = h.is_udp;
                        raw = port_test(d2[acl_match_pkg::D2_PC_LO +: 2], port, d0);
                    end
                    default:
                    begin
                        applies = h.is_tcp;
                        raw = (h.tcp_seq == d0);
                    end
                endcase
            end
            default: applies = 1'b0; // disabled rule never true
        endcase
        rule_result = applies && (c.equal_polarity ? raw : !raw); // [RULE8]
    endfunction

    // ----------------------------------------------------------------
    // evaluation
    // ----------------------------------------------------------------
    logic [acl_match_pkg::ENTRIES-1:0] result;
    logic [acl_match_pkg::ENTRIES-1:0] count_rule;
    logic [acl_match_pkg::ENTRIES-1:0] proc_hit;
    logic [acl_match_pkg::ENTRIES-1:0] action_req;

    genvar g;
    generate
        for (g = 0; g < acl_match_pkg::ENTRIES; g++)
        begin : g_rule
            assign count_rule[g] = is_count_mode(st.mctrl[g]);
            // every rule is evaluated in parallel on each frame
            assign result[g] = rule_result(st.mctrl[g], st.d0[g], st.d1[g], st.d2[g],
                                           FRAME_HDR); // [RULE19]
            assign proc_hit[g] = (st.proc[g].match_select_mask != 16'h0000) &&
                (&(result & ~count_rule | ~st.proc[g].match_select_mask)); // [RULE2] [RULE20]
        end
    endgenerate

    always_comb
    begin
        action_req = 16'h0000;
        for (int p = 0; p < acl_match_pkg::ENTRIES; p++)
        begin
            if (proc_hit[p])
            begin
                action_req[st.proc[p].action_pointer] = 1'b1; // [RULE1] [RULE4]
            end
        end
        action_req = action_req & ~count_rule; // [RULE10]
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [acl_match_pkg::IDX_W-1:0] widx;
        logic [acl_match_pkg::SEL_W-1:0] wsel;
        logic found;
        logic tick;
        logic [acl_match_pkg::CNT_W-1:0] load;
        widx = REG_ADDR[acl_match_pkg::ADDR_W-1:acl_match_pkg::SEL_W];
        wsel = REG_ADDR[acl_match_pkg::SEL_W-1:0];
        found = 1'b0;
        tick = 1'b0;
        load = 11'h000;
        next_st = st;

        // time base
        next_st.us_tick = 1'b0;
        next_st.ms_tick = 1'b0;
        if (st.us_div == 5'(acl_match_pkg::CYCLES_PER_US - 1))
        begin
            next_st.us_div = 5'h00;
            next_st.us_tick = 1'b1;
            if (st.ms_div == 10'(acl_match_pkg::US_PER_MS - 1))
            begin
                next_st.ms_div = 10'h000;
                next_st.ms_tick = 1'b1;
            end
            else
            begin
                next_st.ms_div = st.ms_div + 10'h001;
            end
        end
        else
        begin
            next_st.us_div = st.us_div + 5'h01;
        end

        // register read, data valid the cycle after the strobe
        next_st.rdata = 32'h0;
        if (REG_READ)
        begin
            case (wsel)
                acl_match_pkg::SEL_MATCH_CTRL:
                    next_st.rdata = {26'h0, st.mctrl[widx]};
                acl_match_pkg::SEL_MATCH_D0: next_st.rdata = st.d0[widx];
                acl_match_pkg::SEL_MATCH_D1: next_st.rdata = st.d1[widx];
                acl_match_pkg::SEL_MATCH_D2: next_st.rdata = st.d2[widx];
                acl_match_pkg::SEL_ACTION: next_st.rdata = {12'h0, st.act[widx]};
                acl_match_pkg::SEL_PROC: next_st.rdata = {12'h0, st.proc[widx]};
                acl_match_pkg::SEL_COUNT: next_st.rdata = {21'h0, st.cnt[widx]};
                default: next_st.rdata = 32'h0;
            endcase
        end

        // decision, one cycle after the header strobe
        next_st.dec_valid = FRAME_VALID;
        next_st.dec = '0;
        if (FRAME_VALID)
        begin
            for (int a = acl_match_pkg::ENTRIES - 1; a >= 0; a--)
            begin
                if (action_req[a])
                begin
                    next_st.dec.index = 4'(a); // [RULE3]
                    found = 1'b1;
                end
            end
            if (found)
            begin
                next_st.dec.hit = 1'b1;
                next_st.dec.priority_mode_field = st.act[next_st.dec.index].priority_mode_field;
                next_st.dec.priority_value = st.act[next_st.dec.index].priority_value;
                next_st.dec.remark_enable_field = st.act[next_st.dec.index].remark_enable_field;
                next_st.dec.remark_value_field = st.act[next_st.dec.index].remark_value_field;
                next_st.dec.map_mode_field = st.act[next_st.dec.index].map_mode_field;
                next_st.dec.forward = st.act[next_st.dec.index].forward;
            end
            // no hit: all-zero fields mean no priority change, no remap [RULE21]
        end

        // counters
        next_st.event_out = 16'h0000;
        for (int i = 0; i < acl_match_pkg::ENTRIES; i++)
        begin
            load = st.act[i][acl_match_pkg::CNT_W-1:0]; // [RULE9]
            tick = st.act[i].count_time_unit ? st.ms_tick : st.us_tick; // [RULE11]
            if (count_rule[i])
            begin
                if (!st.act[i].count_algorithm)
                begin
                    if (FRAME_VALID && result[i])
                    begin
                        next_st.cnt[i] = load; // [RULE12]
                    end
                    else if (tick)
                    begin
                        if (st.cnt[i] == 11'h000)
                        begin
                            next_st.cnt[i] = load;
                        end
                        else if (st.cnt[i] == 11'h001)
                        begin
                            next_st.event_out[i] = 1'b1; // [RULE12] [RULE20]
                            next_st.cnt[i] = load;
                        end
                        else
                        begin
                            next_st.cnt[i] = st.cnt[i] - 11'h001; // [RULE12]
                        end
                    end
                end
                else if (FRAME_VALID && result[i])
                begin
                    if (st.cnt[i] + 11'h001 >= load)
                    begin
                        next_st.event_out[i] = 1'b1; // [RULE13] [RULE20]
                        next_st.cnt[i] = 11'h000;
                    end
                    else
                    begin
                        next_st.cnt[i] = st.cnt[i] + 11'h001; // [RULE13]
                    end
                end
            end
            else
            begin
                next_st.cnt[i] = 11'h000;
            end
        end

        // register write; rewriting an entry's match control or action word rearms its counter
        if (REG_WRITE)
        begin
            case (wsel)
                acl_match_pkg::SEL_MATCH_CTRL:
                begin
                    next_st.mctrl[widx] = REG_WDATA[acl_match_pkg::CTRL_W-1:0];
                    next_st.cnt[widx] = 11'h000;
                end
                acl_match_pkg::SEL_MATCH_D0: next_st.d0[widx] = REG_WDATA;
                acl_match_pkg::SEL_MATCH_D1: next_st.d1[widx] = REG_WDATA;
                acl_match_pkg::SEL_MATCH_D2: next_st.d2[widx] = REG_WDATA;
                acl_match_pkg::SEL_ACTION:
                begin
                    next_st.act[widx] = REG_WDATA[acl_match_pkg::ACTION_W-1:0];
                    next_st.cnt[widx] = 11'h000;
                end
                acl_match_pkg::SEL_PROC:
                    next_st.proc[widx] = REG_WDATA[acl_match_pkg::PROC_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign REG_RDATA = st.rdata;
    assign DECISION_VALID = st.dec_valid;
    assign DECISION = st.dec;
    assign COUNT_EVENT = st.event_out;
endmodule // acl_match_engine

// *** sim/acl_frame_source.sv ***
// frame source model standing in for the ingress header parser
// assumes the bench asks for one header per send pulse
`timescale 1ns/1ps
module acl_frame_source
(
    input wire logic CLK,
    input wire logic send,
    input wire acl_match_pkg::frame_hdr_s hdr,
    output logic frame_valid = 1'h0,
    output acl_match_pkg::frame_hdr_s frame_hdr = '0
);
    // header is only held with its strobe; afterwards it flips every cycle
    always @(posedge CLK)
    begin
        frame_valid <= send;
        frame_hdr <= send ? hdr : ~frame_hdr;
    end
endmodule // acl_frame_source

// *** sim/acl_match_checker.sv ***
// port assertions for the acl match engine
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module acl_match_checker
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [acl_match_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic [31:0] REG_RDATA,
    input wire logic FRAME_VALID,
    input wire logic DECISION_VALID,
    input wire acl_match_pkg::decision_s DECISION
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_proc_write;
        REG_WRITE && REG_ADDR[2:0] == acl_match_pkg::SEL_PROC;
    endsequence
    sequence s_same_read;
        REG_READ && REG_ADDR == $past(REG_ADDR);
    endsequence
    a_proc_readback: assert property (s_proc_write ##1 s_same_read |=>
        REG_RDATA == {12'h000, $past(REG_WDATA[19:0], 2)}) else $error("proc readback wrong");
    a_decision_next: assert property (FRAME_VALID |=> DECISION_VALID)
        else $error("decision missing after frame");
    a_decision_lone: assert property (!FRAME_VALID |=> !DECISION_VALID)
        else $error("decision without frame");
    a_decision_idle: assert property (!DECISION_VALID |-> DECISION == '0)
        else $error("decision fields outside valid");
    a_miss_unchanged: assert property (DECISION_VALID && !DECISION.hit |->
        DECISION.forward == '0 && DECISION.map_mode_field == 2'h0 &&
        DECISION.priority_mode_field == 2'h0) else $error("miss alters forwarding");
    a_rdata_idle: assert property (!REG_READ |=> REG_RDATA == 32'h0)
        else $error("read data without read");
    a_unmapped_zero: assert property (REG_READ && REG_ADDR[2:0] == 3'h7 |=> REG_RDATA == 32'h0)
        else $error("unmapped word not zero");
    a_ctrl_width: assert property (REG_READ && REG_ADDR[2:0] == 3'h0 |=>
        REG_RDATA[31:6] == '0) else $error("match control upper bits set");
    a_count_width: assert property (REG_READ && REG_ADDR[2:0] == 3'h6 |=>
        REG_RDATA[31:11] == '0) else $error("counter upper bits set");
endmodule // acl_match_checker
bind acl_match_engine acl_match_checker chk_i (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
    .FRAME_VALID(FRAME_VALID), .DECISION_VALID(DECISION_VALID), .DECISION(DECISION));

// *** sim/test_acl_match_engine.sv ***
// self-checking bench for the acl match engine
// assumes the frame source model and the bound checker
`timescale 1ns/1ps
module test_acl_match_engine;
    logic CLK = 1'h0;
    logic RST = 1'h1;
    logic [acl_match_pkg::ADDR_W-1:0] REG_ADDR = '0;
    logic [31:0] REG_WDATA = '0;
    logic REG_WRITE = 1'h0;
    logic REG_READ = 1'h0;
    logic [31:0] REG_RDATA;
    logic FRAME_VALID;
    acl_match_pkg::frame_hdr_s FRAME_HDR;
    logic DECISION_VALID;
    acl_match_pkg::decision_s DECISION;
    logic [15:0] COUNT_EVENT;
    logic send = 1'h0;
    acl_match_pkg::frame_hdr_s h = '0;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    acl_match_engine uut (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
        .FRAME_VALID(FRAME_VALID), .FRAME_HDR(FRAME_HDR), .DECISION_VALID(DECISION_VALID),
        .DECISION(DECISION), .COUNT_EVENT(COUNT_EVENT));
    acl_frame_source src (.CLK(CLK), .send(send), .hdr(h), .frame_valid(FRAME_VALID),
        .frame_hdr(FRAME_HDR));
    initial forever #20 CLK = ~CLK;
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [6:0] a, input logic [31:0] d);
        @(posedge CLK);
        REG_WRITE <= w;
        REG_READ <= r;
        REG_ADDR <= a;
        REG_WDATA <= d;
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        bus(1'h1, 1'h0, a, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] exp);
        bus(1'h0, 1'h1, a, 32'h0);
        bus(1'h0, 1'h0, a, 32'h0);
        #1;
        chk(REG_RDATA, exp);
    endtask
    task automatic rule(input logic [3:0] e, input logic [31:0] c, d0, d1);
        wr({e, 3'h0}, c);
        wr({e, 3'h1}, d0);
        wr({e, 3'h2}, d1);
    endtask
    task automatic frm(input logic eh, input logic [3:0] ei, input logic [6:0] fw);
        bus(1'h0, 1'h0, 7'h00, 32'h0);
        send <= 1'h1;
        @(posedge CLK);
        send <= 1'h0;
        @(posedge CLK);
        #1;
        chk(DECISION_VALID, 1'h1);
        chk({DECISION.hit, DECISION.index, DECISION.forward}, {eh, ei, fw});
    endtask
    task automatic rst;
        @(posedge CLK);
        RST <= 1'h1;
        REG_WRITE <= 1'h0;
        repeat (2) @(posedge CLK);
        RST <= 1'h0;
        h = '0;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rd(7'h00, 32'h0);
        wr(7'h05, 32'hfff1_2342);
        rd(7'h05, 32'h0001_2342);
        wr(7'h06, 32'h0000_07ff);
        rd(7'h06, 32'h0);
        wr(7'h07, 32'hffff_ffff);
        rd(7'h07, 32'h0);
        wr(7'h00, 32'hffff_ffff);
        rd(7'h00, 32'h0000_003f);
        $display("test regs done");
    endtask
    task automatic t_l2;
        rst();
        rule(4'h0, 32'h15, 32'h3344_5566, 32'h0800_1122);
        wr(7'h05, 32'h12);
        wr(7'h14, 32'h000a_a5ad);
        h.dst_mac = 48'h1122_3344_5566;
        frm(1'h1, 4'h2, 7'h55);
        chk(DECISION, {1'h1, 4'h2, 2'h1, 3'h3, 1'h1, 3'h6, 2'h2, 7'h55});
        h.dst_mac = 48'h1122_3344_5567;
        frm(1'h0, 4'h0, 7'h00);
        wr(7'h00, 32'h14);
        frm(1'h1, 4'h2, 7'h55);
        wr(7'h00, 32'h19);
        h.ethertype = 16'h0800;
        frm(1'h1, 4'h2, 7'h55);
        wr(7'h00, 32'h04);
        frm(1'h0, 4'h0, 7'h00);
        wr(7'h00, 32'h15);
        rule(4'h1, 32'h19, 32'h0, 32'h0800_0000);
        wr(7'h0d, 32'h21);
        wr(7'h0c, 32'h0002_2000);
        h.dst_mac = 48'h1122_3344_5566;
        frm(1'h1, 4'h1, 7'h11);
        wr(7'h1d, 32'h11);
        h.ethertype = 16'h86dd;
        frm(1'h1, 4'h1, 7'h11);
        wr(7'h1d, 32'h31);
        frm(1'h1, 4'h2, 7'h55);
        $display("test layer2 done");
    endtask
    task automatic t_l3;
        rst();
        rule(4'hf, 32'h27, 32'hc0a8_0100, 32'h0000_00ff);
        wr(7'h7d, 32'h0008_0005);
        wr(7'h2c, 32'h0000_6000);
        h.ip_valid = 1'h1;
        h.src_ip = 32'hc0a8_01ab;
        frm(1'h1, 4'h5, 7'h03);
        h.src_ip = 32'hc0a8_02ab;
        h.dst_ip = 32'hc0a8_01ab;
        frm(1'h0, 4'h0, 7'h00);
        rule(4'hf, 32'h29, 32'h0a00_0001, 32'h0a00_0002);
        h.src_ip = 32'h0a00_0001;
        h.dst_ip = 32'h0a00_0002;
        frm(1'h1, 4'h5, 7'h03);
        h.dst_ip = 32'h0a00_0003;
        frm(1'h0, 4'h0, 7'h00);
        wr(7'h78, 32'h31);
        wr(7'h7b, 32'h46);
        h.protocol = 8'h11;
        frm(1'h1, 4'h5, 7'h03);
        h.protocol = 8'h06;
        frm(1'h0, 4'h0, 7'h00);
        rule(4'hf, 32'h39, 32'h0400_0000, 32'h0);
        h.is_udp = 1'h1;
        frm(1'h1, 4'h5, 7'h03);
        $display("test layer3 done");
    endtask
    task automatic t_count;
        int n;
        rst();
        rule(4'h3, 32'h11, 32'h3344_5566, 32'h0800_1122);
        wr(7'h1d, 32'h83);
        wr(7'h1c, 32'h0000_1003);
        h.dst_mac = 48'h1122_3344_5566;
        h.ethertype = 16'h0800;
        for (n = 0; n < 3; n++)
        begin
            frm(1'h0, 4'h0, 7'h00);
            chk(COUNT_EVENT, (n == 2) ? 16'h0008 : 16'h0000);
        end
        wr(7'h1c, 32'h0000_0002);
        bus(1'h0, 1'h0, 7'h00, 32'h0);
        n = 0;
        while (COUNT_EVENT[3] !== 1'h1 && n < 200)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk(n >= 45 && n <= 80, 1'h1);
        $display("test counters done");
    endtask
    initial
    begin
        repeat (2) @(posedge CLK);
        RST <= 1'h0;
        t_regs();
        t_l2();
        t_l3();
        t_count();
        stop_test();
    end
endmodule // test_acl_match_engine
